// ---- src/core_slice_pkg.sv ----
// Shared constants, enumerations and carriers for the core slice
package core_slice_pkg;
   localparam int PC_W = 12;
   localparam int PM_WORDS = 4096;
   localparam int PM_DATA_W = 16;
   localparam int PM_STORED_W = 16;
   localparam int STACK_LEVELS = 4;
   localparam int SP_W = 3;
   localparam logic [11:0] RESET_VECTOR = 12'h000;
   localparam logic [11:0] INT_VECTOR = 12'h004;
   localparam logic [3:0] LAST_PAGE = 4'hF;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] TBL_RST = 8'h00;
   localparam logic [3:0] TBHP_RST = 4'h0;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [SP_W-1:0] SP_EMPTY = 3'h0;
   localparam logic [SP_W-1:0] SP_FULL = 3'h4;
   localparam logic [3:0] BCD_LIMIT = 4'h9;
   localparam logic [7:0] BCD_LOW_FIX = 8'h06;
   localparam logic [7:0] BCD_HIGH_FIX = 8'h60;

   typedef enum logic [4:0] {
      OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
      OP_SBC = 5'h04, OP_AND = 5'h05, OP_OR = 5'h06, OP_XOR = 5'h07,
      OP_CPL = 5'h08, OP_RR = 5'h09, OP_RRC = 5'h0A, OP_RL = 5'h0B,
      OP_RLC = 5'h0C, OP_INC = 5'h0D, OP_DEC = 5'h0E, OP_DECIMAL_ADJUST = 5'h0F,
      OP_MOV_A = 5'h10, OP_JMP = 5'h11, OP_CALL = 5'h12, OP_SUBROUTINE_EXIT = 5'h13,
      OP_INTERRUPT_EXIT = 5'h14, OP_TABLE_FETCH = 5'h15,
      OP_LAST_PAGE_TABLE_FETCH = 5'h16, OP_WR_PC_LOW_BYTE = 5'h17,
      OP_WR_TBL_PTR_LOW = 5'h18, OP_WR_TBL_PTR_HIGH = 5'h19
   } op_t;

   typedef enum logic [3:0] {
      PH_T1 = 4'b0001, PH_T2 = 4'b0010, PH_T3 = 4'b0100, PH_T4 = 4'b1000
   } phase_t;

   typedef struct packed {
      logic ov;
      logic z;
      logic ac;
      logic c;
   } status_t;

   localparam status_t STATUS_RST = 4'h0;

   typedef struct packed {
      op_t op;
      logic to_mem;
      logic [7:0] operand;
      logic [11:0] target;
   } cmd_t;

   typedef struct packed {
      logic [7:0] res;
      status_t st;
   } alu_out_t;
endpackage

// ---- src/return_stack.sv ----
// Four-level return-address stack, hidden from software
`timescale 1ns/10ps
`default_nettype none
module return_stack
(
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire logic push_in,
   input wire logic pop_in,
   input wire logic [11:0] push_pc_in,
   output logic [11:0] top_pc_out,
   output logic full_out
);
   logic [11:0] lev_q [core_slice_pkg::STACK_LEVELS];
   logic [core_slice_pkg::SP_W-1:0] sp_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Shift register: overflow drops the oldest at the bottom
   genvar gi;
   generate
      for (gi = 0; gi < core_slice_pkg::STACK_LEVELS; gi++)
      begin : g_lev
         always_ff @(posedge sys_clk_in)
         begin
            if (!nrst_in)
               lev_q[gi] <= core_slice_pkg::RESET_VECTOR;
            else if (push_in)
               lev_q[gi] <= (gi == 0) ? push_pc_in : lev_q[(gi == 0) ? 0 : gi - 1];
            else if (pop_in && gi < core_slice_pkg::STACK_LEVELS - 1)
               lev_q[gi] <= lev_q[(gi < core_slice_pkg::STACK_LEVELS - 1) ? gi + 1 : gi];
         end
      end
   endgenerate

   // Pointer is internal only; saturates so an overflowing call still pushes
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
         sp_q <= core_slice_pkg::SP_EMPTY;
      else if (push_in && sp_q != core_slice_pkg::SP_FULL)
         sp_q <= sp_q + 3'h1;
      else if (pop_in && !push_in && sp_q != core_slice_pkg::SP_EMPTY)
         sp_q <= sp_q - 3'h1;
   end

   assign top_pc_out = lev_q[0];
   assign full_out = (sp_q == core_slice_pkg::SP_FULL);

   ////////////////////////////////////////////////////////////////////////////////
   property p_overflow_push;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      push_in && full_out |=> full_out && top_pc_out == $past(push_pc_in);
   endproperty
   a_overflow_push: assert property (p_overflow_push) else $error("overflow push lost");

   property p_pop_frees;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      pop_in && !push_in && full_out |=> !full_out;
   endproperty
   a_pop_frees: assert property (p_pop_frees) else $error("pop did not free level");

   property p_reset_empty;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      $rose(nrst_in) |-> sp_q == 3'h0 && !full_out;
   endproperty
   a_reset_empty: assert property (p_reset_empty) else $error("stack not empty at reset");
endmodule
`default_nettype wire

// ---- src/pc_stack_alu_table_read.sv ----
// Program counter, stack control, ALU and table-read slice of the core
// Summary of operation
// - Four-level stack holds program counter only
// - Stack pointer and levels hidden from software
// - Call or interrupt acknowledge pushes program counter
// - Exit instructions reload program counter from stack
// - Reset leaves stack empty
// - Full stack: interrupt latched, acknowledge withheld
// - Exit frees level, pending interrupt then serviced
// - Call on full stack pushes, oldest lost
// - Result to destination, status flags updated
// - Add, subtract with carry, decimal adjust
// - And, or, xor, complement to either destination
// - Rotates, increment, decrement to either destination
// - Program memory is 4K words of 16 bits
// - Reset starts fetching at address zero
// - Table address from low and high pointers, or last page and low pointer
// - Table low byte to operand, high byte kept
// - Unstored high bits read as zero
// - Table high byte changes only by table read
// - Table instructions take two instruction cycles
// - 12-bit counter, low byte writable, low byte write jumps within page
// - Four phases per cycle, fetch in first
// - Branches take two cycles, prefetch discarded
`timescale 1ns/10ps
`default_nettype none
module pc_stack_alu_table_read
(
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire core_slice_pkg::cmd_t cmd_in,
   input wire logic cmd_valid_in,
   input wire logic int_req_in,
   input wire logic int_en_in,
   input wire logic pm_we_in,
   input wire logic [11:0] pm_addr_in,
   input wire logic [15:0] pm_data_in,
   output logic [11:0] pc_out,
   output logic [15:0] fetch_word_out,
   output logic fetch_valid_out,
   output logic [7:0] acc_out,
   output core_slice_pkg::status_t status_out,
   output logic [7:0] table_high_byte_out,
   output logic [7:0] mem_wdata_out,
   output logic mem_we_out,
   output logic int_pending_out,
   output logic int_ack_out,
   output logic stack_full_out,
   output core_slice_pkg::phase_t phase_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [15:0] pmem [core_slice_pkg::PM_WORDS];
   core_slice_pkg::phase_t phase_q;
   core_slice_pkg::phase_t phase_d;
   logic [11:0] pc_q;
   logic [15:0] fetch_q;
   logic fetch_valid_q;
   logic dummy_q;
   logic [7:0] acc_q;
   core_slice_pkg::status_t st_q;
   logic [7:0] tbl_ptr_low_q;
   logic [3:0] tbl_ptr_high_q;
   logic [7:0] table_high_byte_q;
   logic [7:0] mem_wdata_q;
   logic mem_we_q;
   logic pend_q;
   logic ack_q;
   logic full_q;
   logic stack_full;
   logic [11:0] stack_top;
   logic exec;
   logic ack_now;
   logic is_alu;
   logic is_branch;
   logic is_table;
   logic is_push;
   logic is_pop;
   logic [11:0] tbl_addr;
   logic [15:0] tbl_word;
   core_slice_pkg::alu_out_t alu;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode helpers
   function automatic logic op_is_alu(input core_slice_pkg::op_t op);
      op_is_alu = (op >= core_slice_pkg::OP_ADD) && (op <= core_slice_pkg::OP_MOV_A);
   endfunction

   function automatic logic op_is_table(input core_slice_pkg::op_t op);
      op_is_table = (op == core_slice_pkg::OP_TABLE_FETCH) ||
         (op == core_slice_pkg::OP_LAST_PAGE_TABLE_FETCH);
   endfunction

   function automatic logic op_is_exit(input core_slice_pkg::op_t op);
      op_is_exit = (op == core_slice_pkg::OP_SUBROUTINE_EXIT) ||
         (op == core_slice_pkg::OP_INTERRUPT_EXIT);
   endfunction

   // Bits above the stored program width come back as zero
   function automatic logic [7:0] high_byte(input logic [15:0] w);
      logic [15:0] mask;
      mask = 16'hFFFF >> (core_slice_pkg::PM_DATA_W - core_slice_pkg::PM_STORED_W);
      high_byte = 8'((w & mask) >> 8);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // ALU
   function automatic core_slice_pkg::alu_out_t alu_f(input core_slice_pkg::op_t op,
      input logic [7:0] a, input logic [7:0] m, input core_slice_pkg::status_t st);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] b;
      logic cin;
      logic arith;
      core_slice_pkg::alu_out_t o;
      s = 9'h000;
      h = 5'h00;
      b = m;
      cin = 1'b0;
      arith = 1'b0;
      o.res = m;
      o.st = st;
      case (op)
         core_slice_pkg::OP_ADD, core_slice_pkg::OP_ADC,
         core_slice_pkg::OP_SUB, core_slice_pkg::OP_SBC:
         begin
            arith = 1'b1;
            // Subtract as add of complement, carry set means no borrow
            b = (op == core_slice_pkg::OP_SUB || op == core_slice_pkg::OP_SBC) ? ~m : m;
            case (op)
               core_slice_pkg::OP_SUB: cin = 1'b1;
               core_slice_pkg::OP_ADC, core_slice_pkg::OP_SBC: cin = st.c;
               default: cin = 1'b0;
            endcase
         end
         core_slice_pkg::OP_AND: o.res = a & m;
         core_slice_pkg::OP_OR: o.res = a | m;
         core_slice_pkg::OP_XOR: o.res = a ^ m;
         core_slice_pkg::OP_CPL: o.res = ~m;
         core_slice_pkg::OP_RR: o.res = {m[0], m[7:1]};
         core_slice_pkg::OP_RL: o.res = {m[6:0], m[7]};
         core_slice_pkg::OP_RRC:
         begin
            o.res = {st.c, m[7:1]};
            o.st.c = m[0];
         end
         core_slice_pkg::OP_RLC:
         begin
            o.res = {m[6:0], st.c};
            o.st.c = m[7];
         end
         core_slice_pkg::OP_INC: o.res = m + 8'h01;
         core_slice_pkg::OP_DEC: o.res = m - 8'h01;
         core_slice_pkg::OP_DECIMAL_ADJUST:
         begin
            s = {1'b0, a};
            if (a[3:0] > core_slice_pkg::BCD_LIMIT || st.ac)
               s = s + {1'b0, core_slice_pkg::BCD_LOW_FIX};
            if (s[7:4] > core_slice_pkg::BCD_LIMIT || st.c || s[8])
               s = s + {1'b0, core_slice_pkg::BCD_HIGH_FIX};
            o.res = s[7:0];
            o.st.c = st.c | s[8];
         end
         default: o.res = m;
      endcase
      if (arith)
      begin
         s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
         o.res = s[7:0];
         o.st.c = s[8];
         o.st.ac = h[4];
         o.st.ov = (a[7] == b[7]) && (s[7] != a[7]);
      end
      // Rotates and move to accumulator leave zero flag alone; everything else reports it
      if (!(op inside {core_slice_pkg::OP_RR, core_slice_pkg::OP_RL,
         core_slice_pkg::OP_RRC, core_slice_pkg::OP_RLC, core_slice_pkg::OP_MOV_A}))
         o.st.z = (o.res == 8'h00);
      alu_f = o;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Combinational decode of the cycle
   always_comb
   begin
      exec = cmd_valid_in && !dummy_q && (phase_q == core_slice_pkg::PH_T4);
      is_alu = exec && op_is_alu(cmd_in.op);
      is_table = exec && op_is_table(cmd_in.op);
      is_pop = exec && op_is_exit(cmd_in.op);
      is_push = exec && (cmd_in.op == core_slice_pkg::OP_CALL);
      is_branch = exec && (is_push || is_pop || cmd_in.op == core_slice_pkg::OP_JMP ||
         cmd_in.op == core_slice_pkg::OP_WR_PC_LOW_BYTE);
      // Held off while full so the interrupt never overflows the stack
      ack_now = (pend_q || int_req_in) && int_en_in && !stack_full && !dummy_q &&
         (phase_q == core_slice_pkg::PH_T1);
      if (cmd_in.op == core_slice_pkg::OP_LAST_PAGE_TABLE_FETCH)
         tbl_addr = {core_slice_pkg::LAST_PAGE, tbl_ptr_low_q};
      else
         tbl_addr = {tbl_ptr_high_q, tbl_ptr_low_q};
      tbl_word = pmem[tbl_addr];
      alu = alu_f(cmd_in.op, acc_q, cmd_in.operand, st_q);
   end

   return_stack u_stack
   (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .push_in(is_push || ack_now),
      .pop_in(is_pop),
      .push_pc_in(pc_q),
      .top_pc_out(stack_top),
      .full_out(stack_full)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Phase sequencer
   always_comb
   begin
      case (phase_q)
         core_slice_pkg::PH_T1: phase_d = core_slice_pkg::PH_T2;
         core_slice_pkg::PH_T2: phase_d = core_slice_pkg::PH_T3;
         core_slice_pkg::PH_T3: phase_d = core_slice_pkg::PH_T4;
         core_slice_pkg::PH_T4: phase_d = core_slice_pkg::PH_T1;
         default: phase_d = core_slice_pkg::PH_T1;
      endcase
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
         phase_q <= core_slice_pkg::PH_T1;
      else
         phase_q <= phase_d;
   end

   // Program memory load port; no reset on the array
   always_ff @(posedge sys_clk_in)
   begin
      if (pm_we_in)
         pmem[pm_addr_in] <= pm_data_in;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Program counter and fetch
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         pc_q <= core_slice_pkg::RESET_VECTOR;
         fetch_q <= core_slice_pkg::WORD_RST;
         fetch_valid_q <= 1'b0;
      end
      else if (ack_now)
      begin
         pc_q <= core_slice_pkg::INT_VECTOR;
         fetch_valid_q <= 1'b0;
      end
      else if (phase_q == core_slice_pkg::PH_T1 && !dummy_q)
      begin
         fetch_q <= pmem[pc_q];
         pc_q <= pc_q + 12'h001;
         fetch_valid_q <= 1'b1;
      end
      else if (exec)
      begin
         fetch_valid_q <= 1'b0;
         case (cmd_in.op)
            core_slice_pkg::OP_JMP, core_slice_pkg::OP_CALL: pc_q <= cmd_in.target;
            core_slice_pkg::OP_SUBROUTINE_EXIT,
            core_slice_pkg::OP_INTERRUPT_EXIT: pc_q <= stack_top;
            core_slice_pkg::OP_WR_PC_LOW_BYTE: pc_q <= {pc_q[11:8], cmd_in.operand};
            default: pc_q <= pc_q;
         endcase
      end
      else if (phase_q == core_slice_pkg::PH_T4)
         fetch_valid_q <= 1'b0;
   end

   // Bubble cycle after a branch, a table fetch or an acknowledge
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
         dummy_q <= 1'b0;
      else if (ack_now)
         dummy_q <= 1'b1;
      else if (phase_q == core_slice_pkg::PH_T4)
         dummy_q <= is_branch || is_table;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Accumulator, status and memory write-back
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         acc_q <= core_slice_pkg::ACC_RST;
         st_q <= core_slice_pkg::STATUS_RST;
         mem_we_q <= 1'b0;
         mem_wdata_q <= core_slice_pkg::ACC_RST;
      end
      else
      begin
         mem_we_q <= 1'b0;
         if (is_alu)
         begin
            st_q <= alu.st;
            // Accumulator-only ops never write memory
            if (cmd_in.to_mem && !(cmd_in.op inside {core_slice_pkg::OP_MOV_A,
               core_slice_pkg::OP_DECIMAL_ADJUST}))
            begin
               mem_we_q <= 1'b1;
               mem_wdata_q <= alu.res;
            end
            else
               acc_q <= alu.res;
         end
         else if (is_table)
         begin
            mem_we_q <= 1'b1;
            mem_wdata_q <= tbl_word[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Table pointers and read-only high byte
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         tbl_ptr_low_q <= core_slice_pkg::TBL_RST;
         tbl_ptr_high_q <= core_slice_pkg::TBHP_RST;
      end
      else if (exec && cmd_in.op == core_slice_pkg::OP_WR_TBL_PTR_LOW)
         tbl_ptr_low_q <= cmd_in.operand;
      else if (exec && cmd_in.op == core_slice_pkg::OP_WR_TBL_PTR_HIGH)
         tbl_ptr_high_q <= cmd_in.operand[3:0];
   end

   // No write path exists; only a table fetch loads it
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
         table_high_byte_q <= core_slice_pkg::TBL_RST;
      else if (is_table)
         table_high_byte_q <= high_byte(tbl_word);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt request latch and acknowledge
   always_ff @(posedge sys_clk_in)
   begin
      if (!nrst_in)
      begin
         pend_q <= 1'b0;
         ack_q <= 1'b0;
         full_q <= 1'b0;
      end
      else
      begin
         ack_q <= ack_now;
         full_q <= stack_full;
         if (int_req_in)
            pend_q <= 1'b1;
         else if (ack_now)
            pend_q <= 1'b0;
      end
   end

   assign pc_out = pc_q;
   assign fetch_word_out = fetch_q;
   assign fetch_valid_out = fetch_valid_q;
   assign acc_out = acc_q;
   assign status_out = st_q;
   assign table_high_byte_out = table_high_byte_q;
   assign mem_wdata_out = mem_wdata_q;
   assign mem_we_out = mem_we_q;
   assign int_pending_out = pend_q;
   assign int_ack_out = ack_q;
   assign stack_full_out = full_q;
   assign phase_out = phase_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_reset_vector;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      $rose(nrst_in) |-> pc_q == 12'h000 && phase_q == core_slice_pkg::PH_T1;
   endproperty
   a_reset_vector: assert property (p_reset_vector) else $error("bad reset vector");

   property p_phase_walk;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      phase_q == core_slice_pkg::PH_T1 |=> phase_q == core_slice_pkg::PH_T2 ##1
         phase_q == core_slice_pkg::PH_T3 ##1 phase_q == core_slice_pkg::PH_T4;
   endproperty
   a_phase_walk: assert property (p_phase_walk) else $error("phase order broken");

   property p_ack_withheld;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      stack_full && phase_q == core_slice_pkg::PH_T1 |=> !ack_q;
   endproperty
   a_ack_withheld: assert property (p_ack_withheld) else $error("ack on full stack");

   property p_call_target;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      is_push |=> pc_q == $past(cmd_in.target) && stack_top == $past(pc_q);
   endproperty
   a_call_target: assert property (p_call_target) else $error("call push wrong");

   property p_branch_bubble;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      is_branch |=> dummy_q [*4] ##1 !dummy_q;
   endproperty
   a_branch_bubble: assert property (p_branch_bubble) else $error("no branch bubble");

   property p_table_two_cycles;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      is_table |=> !fetch_valid_q [*5] ##1 fetch_valid_q;
   endproperty
   a_table_two_cycles: assert property (p_table_two_cycles) else $error("table not 2 cycles");

   property p_pcl_page;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      exec && cmd_in.op == core_slice_pkg::OP_WR_PC_LOW_BYTE |=>
         pc_q[11:8] == $past(pc_q[11:8]) && pc_q[7:0] == $past(cmd_in.operand);
   endproperty
   a_pcl_page: assert property (p_pcl_page) else $error("page jump left page");

   property p_table_high_byte_hold;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      !is_table |=> $stable(table_high_byte_q);
   endproperty
   a_table_high_byte_hold: assert property (p_table_high_byte_hold) else $error("table high changed");

   property p_zero_flag;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      is_alu && !cmd_in.to_mem && cmd_in.op inside {core_slice_pkg::OP_ADD,
         core_slice_pkg::OP_SUB, core_slice_pkg::OP_AND, core_slice_pkg::OP_XOR}
         |=> st_q.z == (acc_q == 8'h00);
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Directed testbench for the core slice
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic sys_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   core_slice_pkg::cmd_t cmd_in = '0;
   logic cmd_valid_in = 1'b0;
   logic int_req_in = 1'b0;
   logic int_en_in = 1'b1;
   logic pm_we_in = 1'b0;
   logic [11:0] pm_addr_in = 12'h000;
   logic [15:0] pm_data_in = 16'h0000;
   logic [11:0] pc_out;
   logic [15:0] fetch_word_out;
   logic fetch_valid_out;
   logic [7:0] acc_out;
   core_slice_pkg::status_t status_out;
   logic [7:0] table_high_byte_out;
   logic [7:0] mem_wdata_out;
   logic mem_we_out;
   logic int_pending_out;
   logic int_ack_out;
   logic stack_full_out;
   core_slice_pkg::phase_t phase_out;
   int fail_count = 0;
   int num_checks = 0;
   int n;
   ////////////////////////////////////////////////////////////////////////////////////////////
   pc_stack_alu_table_read pc_stack_alu_table_read_i (.sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in), .cmd_in(cmd_in), .cmd_valid_in(cmd_valid_in), .int_req_in(int_req_in),
      .int_en_in(int_en_in), .pm_we_in(pm_we_in), .pm_addr_in(pm_addr_in),
      .pm_data_in(pm_data_in), .pc_out(pc_out), .fetch_word_out(fetch_word_out),
      .fetch_valid_out(fetch_valid_out), .acc_out(acc_out), .status_out(status_out),
      .table_high_byte_out(table_high_byte_out), .mem_wdata_out(mem_wdata_out),
      .mem_we_out(mem_we_out), .int_pending_out(int_pending_out), .int_ack_out(int_ack_out),
      .stack_full_out(stack_full_out), .phase_out(phase_out));
   initial
   begin
      forever #50 sys_clk_in = ~sys_clk_in;
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Bubble cycles show fetch_valid low, so only real cycles take a command
   task automatic wait_t4(input logic need_fetch);
      int k;
      k = 0;
      while (!(phase_out === core_slice_pkg::PH_T4 && (fetch_valid_out === 1'b1 || !need_fetch))
         && k < 40)
      begin
         @(negedge sys_clk_in);
         k++;
      end
      chk(16'(k < 40), 16'h0001);
   endtask
   task automatic exec(input core_slice_pkg::op_t op, input logic tm, input logic [7:0] opd,
      input logic [11:0] tgt);
      wait_t4(1'b1);
      cmd_in.op = op;
      cmd_in.to_mem = tm;
      cmd_in.operand = opd;
      cmd_in.target = tgt;
      cmd_valid_in = 1'b1;
      @(negedge sys_clk_in);
      cmd_valid_in = 1'b0;
   endtask
   task automatic pm_wr(input logic [11:0] a, input logic [15:0] d);
      pm_we_in = 1'b1;
      pm_addr_in = a;
      pm_data_in = d;
      @(negedge sys_clk_in);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic alu_test();
      exec(core_slice_pkg::OP_ADD, 1'b0, 8'h35, 12'h000);
      chk(acc_out, 16'h0035);
      exec(core_slice_pkg::OP_ADD, 1'b1, 8'hE0, 12'h000);
      chk(mem_we_out, 16'h0001);
      chk(mem_wdata_out, 16'h0015);
      chk(acc_out, 16'h0035);
      chk(status_out.c, 16'h0001);
      exec(core_slice_pkg::OP_XOR, 1'b0, 8'h35, 12'h000);
      chk(acc_out, 16'h0000);
      chk(status_out.z, 16'h0001);
      exec(core_slice_pkg::OP_SUB, 1'b0, 8'h01, 12'h000);
      chk(acc_out, 16'h00FF);
      chk(status_out.c, 16'h0000);
      exec(core_slice_pkg::OP_RLC, 1'b0, 8'h80, 12'h000);
      chk(acc_out, 16'h0000);
      chk(status_out.c, 16'h0001);
      exec(core_slice_pkg::OP_DECIMAL_ADJUST, 1'b1, 8'h00, 12'h000);
      chk(acc_out, 16'h0060);
      chk(mem_we_out, 16'h0000);
      exec(core_slice_pkg::OP_CPL, 1'b1, 8'h0F, 12'h000);
      chk(mem_wdata_out, 16'h00F0);
   endtask
   task automatic table_test();
      int_en_in = 1'b0;
      exec(core_slice_pkg::OP_WR_TBL_PTR_LOW, 1'b0, 8'h06, 12'h000);
      exec(core_slice_pkg::OP_WR_TBL_PTR_HIGH, 1'b0, 8'h03, 12'h000);
      exec(core_slice_pkg::OP_TABLE_FETCH, 1'b0, 8'h00, 12'h000);
      chk(mem_we_out, 16'h0001);
      chk(mem_wdata_out, 16'h00C3);
      chk(table_high_byte_out, 16'h00A5);
      wait_t4(1'b0);
      chk(fetch_valid_out, 16'h0000);
      exec(core_slice_pkg::OP_LAST_PAGE_TABLE_FETCH, 1'b0, 8'h00, 12'h000);
      chk(mem_wdata_out, 16'h000F);
      chk(table_high_byte_out, 16'h001A);
      exec(core_slice_pkg::OP_INC, 1'b0, 8'h00, 12'h000);
      chk(table_high_byte_out, 16'h001A);
      int_en_in = 1'b1;
   endtask
   task automatic pc_write_test();
      exec(core_slice_pkg::OP_WR_PC_LOW_BYTE, 1'b0, 8'h40, 12'h000);
      chk(pc_out, 16'h0040);
      wait_t4(1'b1);
      chk(fetch_word_out, 16'h5AA5);
      exec(core_slice_pkg::OP_JMP, 1'b0, 8'h00, 12'h306);
      chk(pc_out, 16'h0306);
   endtask
   // Five calls overflow; a held interrupt then waits for a free level
   task automatic stack_test();
      for (int i = 1; i <= 5; i++)
         exec(core_slice_pkg::OP_CALL, 1'b0, 8'h00, 12'(i * 256));
      repeat (2) @(negedge sys_clk_in);
      chk(stack_full_out, 16'h0001);
      int_req_in = 1'b1;
      @(negedge sys_clk_in);
      int_req_in = 1'b0;
      chk(int_pending_out, 16'h0001);
      repeat (12)
      begin
         @(negedge sys_clk_in);
         chk(int_ack_out, 16'h0000);
      end
      exec(core_slice_pkg::OP_SUBROUTINE_EXIT, 1'b0, 8'h00, 12'h000);
      chk(pc_out, 16'h0401);
      n = 0;
      while (int_ack_out !== 1'b1 && n < 30)
      begin
         @(negedge sys_clk_in);
         n++;
      end
      chk(int_ack_out, 16'h0001);
      chk(pc_out, 16'(core_slice_pkg::INT_VECTOR));
      exec(core_slice_pkg::OP_INTERRUPT_EXIT, 1'b0, 8'h00, 12'h000);
      chk(pc_out, 16'h0401);
      for (int i = 3; i >= 1; i--)
      begin
         exec(core_slice_pkg::OP_SUBROUTINE_EXIT, 1'b0, 8'h00, 12'h000);
         chk(pc_out, 16'(i * 256 + 1));
      end
   endtask
   // Reset in mid-run with the stack full must empty it
   task automatic reset_test();
      for (int i = 1; i <= 4; i++)
         exec(core_slice_pkg::OP_CALL, 1'b0, 8'h00, 12'(i * 16));
      repeat (2) @(negedge sys_clk_in);
      chk(stack_full_out, 16'h0001);
      nrst_in = 1'b0;
      repeat (2) @(negedge sys_clk_in);
      nrst_in = 1'b1;
      @(negedge sys_clk_in);
      chk(stack_full_out, 16'h0000);
      chk(pc_out, 16'h0001);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(negedge sys_clk_in);
      chk(pc_out, 16'(core_slice_pkg::RESET_VECTOR));
      chk(phase_out, 16'(core_slice_pkg::PH_T1));
      chk(stack_full_out, 16'h0000);
      chk(table_high_byte_out, 16'h0000);
      nrst_in = 1'b1;
      @(negedge sys_clk_in);
      chk(pc_out, 16'h0001);
      pm_wr(12'h306, 16'hA5C3);
      pm_wr(12'hF06, 16'h1A0F);
      pm_wr(12'h040, 16'h5AA5);
      pm_we_in = 1'b0;
      alu_test();
      table_test();
      pc_write_test();
      stack_test();
      reset_test();
      test_done();
   end
   // Whole run needs well under a thousand clocks
   initial
   begin
      #2000000;
      fail_count++;
      test_done();
   end
endmodule
`default_nettype wire
